// file: rtl/tccta_timer.sv
// two-channel capture/compare timer core, registers as plain ports
// assumes pins synchronous to clk_sys, software writes arrive as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - a 16-bit up-counter is the shared time base, free or modulo
// - wrap point comes from the high and low modulo value pair
// - counter value readable any time without disturbing counting
// - each channel independently selects input capture or output compare
// - three-bit divider select picks seven bus divisions or the external clock
// - capture edge chosen by the channel's two edge select bits
// - active edge copies counter into the channel's two 8-bit value registers
// - capture happens whether the channel flag is set or clear
// - capture sets channel flag; enabled flag raises interrupt request
// - captured count lands three bus cycles after the pin edge
// - later capture overwrites earlier captured value
// - reset leaves channel value registers unchanged
// - compare match sets, clears or toggles pin and sets channel flag
// - unbuffered compare value takes effect immediately when written
// - buffered select on channel 0 links both channels onto channel 0 pin
// - channel 0 first; each overflow passes control to last written pair
// - linked: channel 0 control governs, channel 1 pin becomes general I/O
// - toggle-on-overflow flips the pin when counter reaches modulo value
// - pulse width is time from overflow to compare match
// - overflow flag set at modulo value; enabled flag raises request
// - mode 0:1 unbuffered, 1:0 buffered; buffered bit overrides on channel 0
// - halt bit stops counting; reset bit clears counter and prescaler
module tccta_timer (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] clock_divider_select,
	input wire logic counter_halt,
	input wire logic counter_reset,
	input wire logic overflow_irq_enable,
	input wire logic overflow_flag_clear,
	input wire logic [15:0] modulo_value,
	input wire logic modulo_write,
	input wire logic [1:0] ch_mode,
	input wire logic [1:0] buffered_link_select,
	input wire logic [1:0] unbuffered_mode_select,
	input wire logic [1:0] edge_level_select_hi,
	input wire logic [1:0] edge_level_select_lo,
	input wire logic [1:0] toggle_on_overflow,
	input wire logic [1:0] channel_irq_enable,
	input wire logic [1:0] channel_flag_clear,
	input wire logic [15:0] channel_wdata,
	input wire logic [1:0] channel_write,
	input wire logic ext_timer_clock_pin,
	input wire logic channel0_pin_in,
	input wire logic channel1_pin_in,
	input wire logic channel1_gpio_out,
	input wire logic channel1_gpio_oe,
	output logic channel0_pin_out,
	output logic channel0_pin_oe,
	output logic channel1_pin_out,
	output logic channel1_pin_oe,
	output logic [15:0] counter_value,
	output logic [15:0] channel0_value,
	output logic [15:0] channel1_value,
	output logic overflow_flag,
	output logic channel0_event_flag,
	output logic channel1_event_flag,
	output logic overflow_irq,
	output logic channel0_irq,
	output logic channel1_irq,
	output logic active_pair
);
	// ch_mode bit set means output compare for that channel, except channel 1 while linked; clear leaves it to the buffered and unbuffered select bits
	logic [6:0] prescale;
	logic ext_s1, ext_s2, ext_s3;
	logic tick;
	logic [15:0] modulo;
	logic at_mod;
	logic [1:0] pin_d1, pin_d2;
	logic [1:0] cap_edge;
	logic [1:0] cap_pend;
	logic linked;
	logic last_written;
	logic [1:0] is_cmp;
	logic [1:0] match;
	logic [15:0] cmp_val0;

	assign linked = buffered_link_select[0];
	assign is_cmp[0] = linked | unbuffered_mode_select[0] | ch_mode[0];
	assign is_cmp[1] = ~linked & (unbuffered_mode_select[1] | buffered_link_select[1]
		| ch_mode[1]);

	// divided bus clock or external clock edge
	always_ff @(posedge clk_sys) begin
		if (rst || counter_reset) begin
			prescale <= '0;
		end else if (!counter_halt) begin
			prescale <= prescale + 7'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			ext_s1 <= ext_timer_clock_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end

	always_comb begin
		if (clock_divider_select == tccta_pkg::DIV_EXT) begin
			tick = ext_s2 & ~ext_s3;
		end else if (clock_divider_select == 3'h0) begin
			tick = 1'b1;
		end else begin
			tick = (prescale & ((7'h01 << clock_divider_select) - 7'h01)) == 7'h00;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			modulo <= tccta_pkg::MOD_RESET;
		end else if (modulo_write) begin
			modulo <= modulo_value;
		end
	end

	assign at_mod = counter_value == modulo;
	wire cnt_step = tick & ~counter_halt & ~counter_reset;
	wire ovf_evt = cnt_step & at_mod;

	always_ff @(posedge clk_sys) begin
		if (rst || counter_reset) begin
			counter_value <= '0;
		end else if (cnt_step) begin
			if (at_mod) begin
				counter_value <= '0;
			end else begin
				counter_value <= counter_value + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			overflow_flag <= 1'b0;
		end else if (ovf_evt) begin
			overflow_flag <= 1'b1;
		end else if (overflow_flag_clear) begin
			overflow_flag <= 1'b0;
		end
	end

	// capture edge detection, two cycles to landing; reset loads pin levels, no false edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_d1 <= {channel1_pin_in, channel0_pin_in};
			pin_d2 <= {channel1_pin_in, channel0_pin_in};
			cap_pend <= 2'b00;
		end else begin
			pin_d1 <= {channel1_pin_in, channel0_pin_in};
			pin_d2 <= pin_d1;
			cap_pend <= cap_edge;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_edge
			always_comb begin
				cap_edge[g] = 1'b0;
				if (!is_cmp[g] && !(g == 1 && linked)) begin
					case ({edge_level_select_hi[g], edge_level_select_lo[g]})
						tccta_pkg::ELS_RISE_TOGGLE: cap_edge[g] = pin_d1[g] & ~pin_d2[g];
						tccta_pkg::ELS_FALL_CLEAR: cap_edge[g] = ~pin_d1[g] & pin_d2[g];
						tccta_pkg::ELS_BOTH_SET: cap_edge[g] = pin_d1[g] ^ pin_d2[g];
						default: cap_edge[g] = 1'b0;
					endcase
				end
			end
		end
	endgenerate

	// channel value registers carry no reset
	always_ff @(posedge clk_sys) begin
		if (cap_pend[0]) begin
			channel0_value <= counter_value;
		end else if (channel_write[0]) begin
			channel0_value <= channel_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (cap_pend[1]) begin
			channel1_value <= counter_value;
		end else if (channel_write[1]) begin
			channel1_value <= channel_wdata;
		end
	end

	// linked pair selection
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			last_written <= 1'b0;
		end else if (channel_write[1]) begin
			last_written <= 1'b1;
		end else if (channel_write[0]) begin
			last_written <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !linked) begin
			active_pair <= 1'b0;
		end else if (ovf_evt) begin
			active_pair <= last_written;
		end
	end

	assign cmp_val0 = (linked && active_pair) ? channel1_value : channel0_value;
	assign match[0] = is_cmp[0] & cnt_step & (counter_value == cmp_val0);
	assign match[1] = is_cmp[1] & cnt_step & (counter_value == channel1_value);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			channel0_event_flag <= 1'b0;
		end else if (match[0] || cap_pend[0]) begin
			channel0_event_flag <= 1'b1;
		end else if (channel_flag_clear[0]) begin
			channel0_event_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			channel1_event_flag <= 1'b0;
		end else if (match[1] || cap_pend[1]) begin
			channel1_event_flag <= 1'b1;
		end else if (channel_flag_clear[1]) begin
			channel1_event_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			overflow_irq <= 1'b0;
			channel0_irq <= 1'b0;
			channel1_irq <= 1'b0;
		end else begin
			overflow_irq <= overflow_irq_enable & (overflow_flag | ovf_evt);
			channel0_irq <= channel_irq_enable[0] & (channel0_event_flag | match[0]
				| cap_pend[0]);
			channel1_irq <= channel_irq_enable[1] & (channel1_event_flag | match[1]
				| cap_pend[1]) & ~linked;
		end
	end

	// pin drive; compare action wins over overflow toggle in the same tick
	function automatic logic next_pin(input logic cur, input logic m, input logic ov,
		input logic tov, input logic [1:0] els);
		logic v;
		v = cur;
		if (ov && tov) begin
			v = ~v;
		end
		if (m) begin
			case (els)
				tccta_pkg::ELS_RISE_TOGGLE: v = ~cur;
				tccta_pkg::ELS_FALL_CLEAR: v = 1'b0;
				tccta_pkg::ELS_BOTH_SET: v = 1'b1;
				default: v = v;
			endcase
		end
		return v;
	endfunction : next_pin

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			channel0_pin_out <= 1'b0;
			channel0_pin_oe <= 1'b0;
		end else begin
			channel0_pin_oe <= is_cmp[0] && {edge_level_select_hi[0], edge_level_select_lo[0]}
				!= tccta_pkg::ELS_NONE;
			channel0_pin_out <= next_pin(channel0_pin_out, match[0], ovf_evt,
				toggle_on_overflow[0], {edge_level_select_hi[0], edge_level_select_lo[0]});
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			channel1_pin_out <= 1'b0;
			channel1_pin_oe <= 1'b0;
		end else if (linked) begin
			channel1_pin_out <= channel1_gpio_out;
			channel1_pin_oe <= channel1_gpio_oe;
		end else begin
			channel1_pin_oe <= is_cmp[1] && {edge_level_select_hi[1], edge_level_select_lo[1]}
				!= tccta_pkg::ELS_NONE;
			channel1_pin_out <= next_pin(channel1_pin_out, match[1], ovf_evt,
				toggle_on_overflow[1], {edge_level_select_hi[1], edge_level_select_lo[1]});
		end
	end

	property p_wrap;
		@(posedge clk_sys) disable iff (rst)
		(cnt_step && at_mod) |=> counter_value == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_count;
		@(posedge clk_sys) disable iff (rst)
		(cnt_step && !at_mod) |=> counter_value == $past(counter_value) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("counter did not advance");

	property p_halt;
		@(posedge clk_sys) disable iff (rst)
		(counter_halt && !counter_reset) |=> $stable(counter_value);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted");

	property p_clr;
		@(posedge clk_sys) disable iff (rst)
		counter_reset |=> counter_value == 16'h0000 && prescale == 7'h00;
	endproperty
	a_clr: assert property (p_clr) else $error("counter reset failed");

	sequence s_cap_rise;
		!pin_d1[0] ##1 pin_d1[0] && !is_cmp[0]
			&& {edge_level_select_hi[0], edge_level_select_lo[0]} == tccta_pkg::ELS_RISE_TOGGLE;
	endsequence
	property p_cap;
		@(posedge clk_sys) disable iff (rst)
		s_cap_rise |=> ##1 channel0_value == $past(counter_value) && channel0_event_flag;
	endproperty
	a_cap: assert property (p_cap) else $error("capture missed");

	property p_ovf;
		@(posedge clk_sys) disable iff (rst)
		ovf_evt |=> overflow_flag;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag not set");

	property p_cmp_flag;
		@(posedge clk_sys) disable iff (rst)
		match[1] |=> channel1_event_flag;
	endproperty
	a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");

	property p_clear_pin;
		@(posedge clk_sys) disable iff (rst)
		(match[0] && {edge_level_select_hi[0], edge_level_select_lo[0]}
			== tccta_pkg::ELS_FALL_CLEAR) |=> !channel0_pin_out;
	endproperty
	a_clear_pin: assert property (p_clear_pin) else $error("pin not cleared");

	property p_link;
		@(posedge clk_sys) disable iff (rst)
		(linked && ovf_evt) |=> active_pair == $past(last_written);
	endproperty
	a_link: assert property (p_link) else $error("pair not switched");
endmodule : tccta_timer
`default_nettype wire

// file: rtl/tccta_pkg.sv
// package for the two-channel capture/compare timer
// assumes a single clk_sys domain at 25 MHz
package tccta_pkg;
	localparam int CNT_W = 16;
	localparam logic [15:0] MOD_RESET = 16'hFFFF;
	localparam logic [2:0] DIV_EXT = 3'h7;
	localparam int CAP_DELAY = 2;
	// edge/level select codes
	localparam logic [1:0] ELS_NONE = 2'h0;
	localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
	localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
	localparam logic [1:0] ELS_BOTH_SET = 2'h3;
endpackage : tccta_pkg

// file: tb/tccta_pins.sv
// pin-side model: external clock source and capture pin drivers
// assumes one-cycle request strobes on clk_sys
`timescale 1ns/1ps
`default_nettype none
module tccta_pins (
	input wire logic clk_sys,
	input wire logic ext_pulse,
	input wire logic [1:0] pin_flip,
	input wire logic ch0_out,
	input wire logic ch0_oe,
	output logic ext_clk,
	output logic ch0_wire,
	output logic ch1_wire
);
	logic [1:0] lvl = 2'h0;
	logic [1:0] ext_cnt = 2'h0;
	always_ff @(posedge clk_sys) begin
		lvl <= lvl ^ pin_flip;
		if (ext_pulse)
			ext_cnt <= 2'h3;
		else if (ext_cnt != 2'h0)
			ext_cnt <= ext_cnt - 2'h1;
	end
	// clock pin stands low between pulses
	assign ext_clk = ext_cnt != 2'h0;
	assign ch0_wire = ch0_oe ? ch0_out : lvl[0];
	assign ch1_wire = lvl[1];
endmodule : tccta_pins
`default_nettype wire

// file: tb/tccta_timer_bench.sv
// self-checking bench for the capture/compare timer core
// assumes tccta_pins as pin model, one clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module tccta_timer_bench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic counter_halt = 1'b1;
	logic counter_reset = 1'b0, overflow_irq_enable = 1'b0, overflow_flag_clear = 1'b0;
	logic modulo_write = 1'b0, ext_pulse = 1'b0, channel1_gpio_out = 1'b0;
	logic channel1_gpio_oe = 1'b0;
	logic [2:0] clock_divider_select = 3'h0;
	logic [15:0] modulo_value = 16'h0000, channel_wdata = 16'h0000;
	logic [1:0] ch_mode = 2'h0, buffered_link_select = 2'h0, edge_level_select_hi = 2'h0;
	logic [1:0] edge_level_select_lo = 2'h0, toggle_on_overflow = 2'h0;
	logic [1:0] channel_irq_enable = 2'h0, channel_flag_clear = 2'h0;
	logic [1:0] channel_write = 2'h0, pin_flip = 2'h0, unbuffered_mode_select = 2'h0;
	logic ext_timer_clock_pin, channel0_pin_in, channel1_pin_in, channel0_pin_out;
	logic channel0_pin_oe, channel1_pin_out, channel1_pin_oe, overflow_flag;
	logic channel0_event_flag, channel1_event_flag, overflow_irq, channel0_irq;
	logic channel1_irq, active_pair;
	logic [15:0] counter_value, channel0_value, channel1_value;
	int err_count = 0;
	int n_tests = 0;
	int tg, h1, h2;
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	tccta_timer DUT (.clk_sys, .rst, .clock_divider_select, .counter_halt, .counter_reset,
		.overflow_irq_enable, .overflow_flag_clear, .modulo_value, .modulo_write, .ch_mode,
		.buffered_link_select, .unbuffered_mode_select, .edge_level_select_hi,
		.edge_level_select_lo, .toggle_on_overflow, .channel_irq_enable, .channel_flag_clear,
		.channel_wdata, .channel_write, .ext_timer_clock_pin, .channel0_pin_in,
		.channel1_pin_in, .channel1_gpio_out, .channel1_gpio_oe, .channel0_pin_out,
		.channel0_pin_oe, .channel1_pin_out, .channel1_pin_oe, .counter_value, .channel0_value,
		.channel1_value, .overflow_flag, .channel0_event_flag, .channel1_event_flag,
		.overflow_irq, .channel0_irq, .channel1_irq, .active_pair);
	tccta_pins u_pins (.clk_sys, .ext_pulse, .pin_flip, .ch0_out(channel0_pin_out),
		.ch0_oe(channel0_pin_oe), .ext_clk(ext_timer_clock_pin), .ch0_wire(channel0_pin_in),
		.ch1_wire(channel1_pin_in));
	task automatic stop_test;
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// sel 1 waits for overflow, 0 for the channel 0 event
	task automatic wait_flag(input logic sel);
		int i;
		for (i = 0; i < 16 && (sel ? overflow_flag : channel0_event_flag) !== 1'b1; i++)
			tick(1);
		if (i == 16) begin
			err_count++;
			$display("ERROR %0t flag never rose", $time);
			stop_test();
		end
	endtask : wait_flag
	task automatic wr_mod(input logic [15:0] v);
		modulo_value = v;
		modulo_write = 1'b1;
		tick(1);
		modulo_write = 1'b0;
	endtask : wr_mod
	task automatic wr_ch(input int i, input logic [15:0] v);
		channel_wdata = v;
		channel_write[i] = 1'b1;
		tick(1);
		channel_write = 2'h0;
	endtask : wr_ch
	task automatic strobe(input int which);
		case (which)
			0: pin_flip = 2'h1;
			1: ext_pulse = 1'b1;
			2: counter_reset = 1'b1;
			default: overflow_flag_clear = 1'b1;
		endcase
		tick(1);
		{pin_flip, ext_pulse, counter_reset, overflow_flag_clear} = 5'h00;
		tick(which == 1 ? 5 : 1);
	endtask : strobe
	task automatic sample(output int tgl, output int hi);
		logic prev;
		tgl = 0;
		hi = 0;
		prev = channel0_pin_out;
		repeat (30) begin
			tick(1);
			tgl += int'(channel0_pin_out !== prev);
			hi += int'(channel0_pin_out === 1'b1);
			prev = channel0_pin_out;
		end
	endtask : sample
	initial begin
		tick(8);
		rst = 1'b0;
		tick(2);
		check(counter_value, 16'h0000);
		check({14'h0000, overflow_flag, channel0_pin_oe}, 16'h0000);
		counter_halt = 1'b0;
		tick(20);
		counter_halt = 1'b1;
		tick(3);
		check(counter_value, 16'h0014);
		tick(5);
		check(counter_value, 16'h0014);
		edge_level_select_lo = 2'h1;
		channel_irq_enable = 2'h1;
		strobe(0);
		check({15'h0000, channel0_event_flag}, 16'h0000);
		tick(1);
		check({15'h0000, channel0_event_flag}, 16'h0000);
		tick(1);
		check({15'h0000, channel0_event_flag}, 16'h0001);
		wait_flag(1'b0);
		tick(2);
		check(channel0_value, 16'h0014);
		check({15'h0000, channel0_irq}, 16'h0001);
		counter_halt = 1'b0;
		tick(7);
		counter_halt = 1'b1;
		strobe(0);
		tick(6);
		check(channel0_value, 16'h0014);
		strobe(0);
		tick(6);
		check(channel0_value, 16'h001B);
		channel_flag_clear = 2'h1;
		tick(1);
		channel_flag_clear = 2'h0;
		tick(1);
		check({15'h0000, channel0_event_flag}, 16'h0000);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(4);
		check(channel0_value, 16'h001B);
		check({15'h0000, channel0_event_flag}, 16'h0000);
		counter_halt = 1'b0;
		wr_mod(16'h0009);
		ch_mode = 2'h1;
		wr_ch(0, 16'h0005);
		strobe(2);
		tick(12);
		sample(tg, h2);
		check(16'(tg), 16'h0003);
		overflow_irq_enable = 1'b1;
		strobe(3);
		wait_flag(1'b1);
		tick(2);
		check({15'h0000, overflow_irq}, 16'h0001);
		ch_mode = 2'h0;
		unbuffered_mode_select = 2'h1;
		toggle_on_overflow = 2'h1;
		edge_level_select_hi = 2'h1;
		edge_level_select_lo = 2'h0;
		wr_ch(0, 16'h0003);
		tick(20);
		sample(tg, h1);
		wr_ch(0, 16'h0006);
		tick(20);
		sample(tg, h2);
		check(16'(h2 - h1), 16'h0009);
		buffered_link_select = 2'h1;
		ch_mode = 2'h2;
		edge_level_select_hi = 2'h3;
		edge_level_select_lo = 2'h2;
		channel_irq_enable = 2'h3;
		channel1_gpio_out = 1'b1;
		channel1_gpio_oe = 1'b1;
		tick(3);
		check({14'h0000, channel1_pin_out, channel1_pin_oe}, 16'h0003);
		check({15'h0000, channel0_pin_oe}, 16'h0001);
		check({15'h0000, active_pair}, 16'h0000);
		channel1_gpio_out = 1'b0;
		wr_ch(1, 16'h0002);
		strobe(3);
		wait_flag(1'b1);
		tick(2);
		check({15'h0000, active_pair}, 16'h0001);
		check({14'h0000, channel1_event_flag, channel1_irq}, 16'h0000);
		buffered_link_select = 2'h0;
		tick(12);
		check({13'h0000, active_pair, channel1_pin_out, channel1_pin_oe}, 16'h0003);
		check({14'h0000, channel1_event_flag, channel1_irq}, 16'h0003);
		check(channel1_value, 16'h0002);
		clock_divider_select = tccta_pkg::DIV_EXT;
		wr_mod(16'hFFFF);
		strobe(2);
		tick(10);
		check(counter_value, 16'h0000);
		repeat (5) strobe(1);
		check(counter_value, 16'h0005);
		stop_test();
	end
endmodule : tccta_timer_bench
`default_nettype wire
